// ---- rtl/asc_pkg.sv ----
// Package for the converter sequencer configuration block.
// Assumes a 32-bit register port and a 12-bit converter core result.
package asc_pkg;

    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int RAW_W     = 12;
    localparam int RES_W     = 16;
    localparam int PAD_W     = RES_W - RAW_W;
    localparam int SLOT_N    = 8;
    localparam int SLOT_W    = 4;
    localparam int TRIG_N    = 8;
    localparam int SAMP_W    = 9;

    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SAMPLE  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CONFIG  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CLKWARM = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_GUARD   = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_LIMITS  = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_SLOT_LO = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_SLOT_HI = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_QUEUE   = 8'h4C;

    // Writable bits per register; all others stay zero
    localparam logic [DATA_W-1:0] CONFIG_WMASK  = 32'h0003_FFFF;
    localparam logic [DATA_W-1:0] CLKWARM_WMASK = 32'h0000_0FFF;
    localparam logic [DATA_W-1:0] SAMPLE_WMASK  = 32'h0000_00FF;
    localparam logic [DATA_W-1:0] GUARD_WMASK   = 32'h0000_003F;
    localparam logic [DATA_W-1:0] LIMITS_WMASK  = 32'h0FFF_0FFF;
    localparam logic [DATA_W-1:0] SLOT_WMASK    = 32'h0000_FFFF;

    localparam logic [DATA_W-1:0] SAMPLE_RESET  = 32'h0000_0002;
    localparam logic [SAMP_W-1:0] SAMPLE_EXTRA  = 9'h002;
    localparam logic [SAMP_W-1:0] SAMPLE_ONE    = 9'h001;

    localparam logic [2:0] TRIG_SW   = 3'h0;
    localparam logic [2:0] TRIG_RISE = 3'h1;
    localparam logic [2:0] TRIG_FALL = 3'h2;
    localparam logic [2:0] TRIG_BOTH = 3'h3;

    localparam logic [RAW_W-1:0] RAW_ONES = 12'hFFF;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_NEXT,
        ST_SAMPLE,
        ST_CONVERT
    } asc_state_e;

    typedef struct packed {
        logic [13:0] rsv;
        logic        overflowPolicy;
        logic [2:0]  slotCount;
        logic        splitSequenceEnable;
        logic        idlePowerDown;
        logic        waitMode;
        logic        repeatConversion;
        logic [2:0]  triggerSourceSelect;
        logic [2:0]  triggerPolaritySelect;
        logic        alignRight;
        logic [1:0]  bitDepthSelect;
        logic        transferRequestEnable;
    } asc_config_s;

    typedef struct packed {
        logic [19:0] rsv;
        logic [7:0]  warmupCount;
        logic [3:0]  clockDivisor;
    } asc_clkwarm_s;

    typedef struct packed {
        logic [23:0] rsv;
        logic [7:0]  sampleWindowLen;
    } asc_sample_s;

    typedef struct packed {
        logic [25:0] rsv;
        logic        guardEnable;
        logic        guardSingleChannel;
        logic [3:0]  guardChannel;
    } asc_guard_s;

    typedef struct packed {
        logic [3:0]  rsvHi;
        logic [11:0] upperLimit;
        logic [3:0]  rsvLo;
        logic [11:0] lowerLimit;
    } asc_limits_s;

    typedef struct packed {
        logic [25:0] rsv;
        logic        ready;
        logic        queueFull;
        logic        analogGuardFlag;
        logic        overflowFlag;
        logic        endOfSequenceFlag;
        logic        endOfConversionFlag;
    } asc_status_s;

    typedef struct packed {
        logic [29:0] rsv;
        logic        convertRun;
        logic        enable;
    } asc_control_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } asc_bus_req_s;

    typedef struct packed {
        logic             done;
        logic [RAW_W-1:0] data;
    } asc_core_res_s;

endpackage : asc_pkg

// ---- rtl/asc_sequencer_config.sv ----
// Converter sequencer: configuration registers, prescaler, warm-up,
// sampling timer, slot sequencer, threshold guard and result holding.
// Assumes a converter core on the same clock and trigger pins from
// outside the clock domain.
// Operation
// - Overrun overwrites holding register only if policy set
// - Sequence length is slot count plus one
// - Split-sequence bit enables discontinuous mode
// - Idle power-down bit enables auto-off
// - Wait bit enables wait conversion mode
// - Repeat bit converts continuously until cleared
// - Source field picks one of eight triggers
// - Mode field picks software or trigger polarity
// - Alignment bit chooses right or left justify
// - Bit depth field selects conversion resolution
// - Transfer enable bit allows transfer requests
// - Converter clock is system clock over divisor+1
// - Warm-up counts converter clocks to warm-up field
// - Sampling lasts window field plus two clocks
// - Guard enable bit switches threshold watchdog
// - Single-channel bit limits guard to one channel
// - Guard channel codes: inputs 0-7, sensor 1111
// - Separate twelve-bit upper and lower limits
// - Slots 0-3 have their own channel fields; slots 4-7 always use channel 0
// - Result queue reads sixteen bits, ignores writes
// - Read-only and reserved bits ignore writes silently
// - Guard flag set on crossing, write-1 clears
// - Overflow flag set on a result while full; write-1 clears
// - Conversion flag cleared by queue read or write-1
// - Software split mode clears run at conversion end
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module asc_sequencer_config (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire asc_pkg::asc_bus_req_s  busReq,
    output logic [asc_pkg::DATA_W-1:0]  busRdata,
    input  wire logic [asc_pkg::TRIG_N-1:0] trigPins,
    input  wire asc_pkg::asc_core_res_s coreRes,
    output logic                        qclkEn,
    output logic                        corePowerOn,
    output logic                        sampleActive,
    output logic                        convertStart,
    output logic [asc_pkg::SLOT_W-1:0]  convChannel,
    output logic [1:0]                  bitDepth,
    output logic                        dmaReq
);
    import asc_pkg::*;

    // Registers
    asc_config_s         config_r;
    asc_clkwarm_s        clkWarm_r;
    asc_sample_s         sample_r;
    asc_guard_s          guard_r;
    asc_limits_s         limits_r;
    logic [DATA_W-1:0]   slotLo_r;
    logic [DATA_W-1:0]   slotHi_r;
    logic                enable_r;
    logic                run_r;
    logic                run_nxt;
    logic                ready_r;
    logic [7:0]          warmCnt_r;
    logic [3:0]          divCnt_r;
    logic                eocFlag_r;
    logic                eoseqFlag_r;
    logic                ovrFlag_r;
    logic                guardFlag_r;
    logic                full_r;
    logic [RES_W-1:0]    hold_r;
    logic [DATA_W-1:0]   busRdata_r;
    logic [TRIG_N-1:0]   trigMeta_r;
    logic [TRIG_N-1:0]   trigSync_r;
    logic                trigPrev_r;
    asc_state_e          state_r;
    asc_state_e          state_nxt;
    logic [2:0]          slotIdx_r;
    logic [2:0]          slotIdx_nxt;
    logic [SAMP_W-1:0]   sampCnt_r;
    logic [SAMP_W-1:0]   sampCnt_nxt;
    logic                qclkEn_r;
    logic                corePowerOn_r;
    logic                sampleActive_r;
    logic                convertStart_r;
    logic [SLOT_W-1:0]   convChannel_r;
    logic                dmaReq_r;
    logic                startPulse;
    logic                runClr;
    logic                eoseqSet;
    logic                lastSlot;

    // Address decode
    logic wrStatus;
    logic wrControl;
    logic wrSample;
    logic wrConfig;
    logic wrClkWarm;
    logic wrGuard;
    logic wrLimits;
    logic wrSlotLo;
    logic wrSlotHi;
    logic queueRd;

    assign wrStatus  = busReq.wr && (busReq.addr == OFS_STATUS);
    assign wrControl = busReq.wr && (busReq.addr == OFS_CONTROL);
    assign wrSample  = busReq.wr && (busReq.addr == OFS_SAMPLE);
    assign wrConfig  = busReq.wr && (busReq.addr == OFS_CONFIG);
    assign wrClkWarm = busReq.wr && (busReq.addr == OFS_CLKWARM);
    assign wrGuard   = busReq.wr && (busReq.addr == OFS_GUARD);
    assign wrLimits  = busReq.wr && (busReq.addr == OFS_LIMITS);
    assign wrSlotLo  = busReq.wr && (busReq.addr == OFS_SLOT_LO);
    assign wrSlotHi  = busReq.wr && (busReq.addr == OFS_SLOT_HI);
    assign queueRd   = busReq.rd && (busReq.addr == OFS_QUEUE);

    asc_status_s  statusW;
    asc_control_s controlW;
    assign statusW  = asc_status_s'(busReq.wdata);
    assign controlW = asc_control_s'(busReq.wdata);

    // Configuration registers; masks keep reserved bits at zero
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            config_r  <= '0;
            clkWarm_r <= '0;
            sample_r  <= asc_sample_s'(SAMPLE_RESET);
            guard_r   <= '0;
            limits_r  <= '0;
            slotLo_r  <= '0;
            slotHi_r  <= '0;
        end
        else
        begin
            if (wrConfig)
                config_r <= asc_config_s'(busReq.wdata & CONFIG_WMASK);
            if (wrClkWarm)
                clkWarm_r <= asc_clkwarm_s'(busReq.wdata & CLKWARM_WMASK);
            if (wrSample)
                sample_r <= asc_sample_s'(busReq.wdata & SAMPLE_WMASK);
            if (wrGuard)
                guard_r <= asc_guard_s'(busReq.wdata & GUARD_WMASK);
            if (wrLimits)
                limits_r <= asc_limits_s'(busReq.wdata & LIMITS_WMASK);
            if (wrSlotLo)
                slotLo_r <= busReq.wdata & SLOT_WMASK;
            if (wrSlotHi)
                slotHi_r <= busReq.wdata & SLOT_WMASK;
        end
    end

    // Slot channel table
    logic [2*DATA_W-1:0] slotWord;
    logic [SLOT_W-1:0]   slotChan [SLOT_N];
    assign slotWord = {slotHi_r, slotLo_r};

    genvar g;
    generate
        for (g = 0; g < SLOT_N; g++)
        begin : gSlot
            assign slotChan[g] = slotWord[g*SLOT_W +: SLOT_W];
        end
    endgenerate

    // Converter clock enable from the prescaler
    logic qTick;
    assign qTick = enable_r && (divCnt_r == clkWarm_r.clockDivisor);

    always_ff @(posedge clk)
    begin
        if (rst || !enable_r || qTick)
            divCnt_r <= '0;
        else
            divCnt_r <= divCnt_r + 4'h1;
    end

    // Warm-up after enable
    always_ff @(posedge clk)
    begin
        if (rst || !enable_r)
        begin
            warmCnt_r <= '0;
            ready_r   <= 1'b0;
        end
        else if (qTick && !ready_r)
        begin
            if (warmCnt_r == clkWarm_r.warmupCount)
                ready_r <= 1'b1;
            else
                warmCnt_r <= warmCnt_r + 8'h01;
        end
    end

    // Control register
    always_comb
    begin
        run_nxt = run_r;
        if (runClr)
            run_nxt = 1'b0;
        if (wrControl)
            run_nxt = controlW.convertRun;
        if (wrControl ? !controlW.enable : !enable_r)
            run_nxt = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            enable_r <= 1'b0;
            run_r    <= 1'b0;
        end
        else
        begin
            if (wrControl)
                enable_r <= controlW.enable;
            run_r <= run_nxt;
        end
    end

    // Trigger pin synchroniser and edge detect
    logic trigSel;
    logic hwMode;
    logic trigHit;
    assign trigSel = trigSync_r[config_r.triggerSourceSelect];
    assign hwMode  = (config_r.triggerPolaritySelect == TRIG_RISE)
                  || (config_r.triggerPolaritySelect == TRIG_FALL)
                  || (config_r.triggerPolaritySelect == TRIG_BOTH);
    assign trigHit = !hwMode
        || ((config_r.triggerPolaritySelect != TRIG_FALL)
            && trigSel && !trigPrev_r)
        || ((config_r.triggerPolaritySelect != TRIG_RISE)
            && !trigSel && trigPrev_r);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            trigMeta_r <= '0;
            trigSync_r <= '0;
            trigPrev_r <= 1'b0;
        end
        else
        begin
            trigMeta_r <= trigPins;
            trigSync_r <= trigMeta_r;
            trigPrev_r <= trigSel;
        end
    end

    // Sequencer
    logic              convDone;
    logic [SAMP_W-1:0] sampLast;
    assign convDone = (state_r == ST_CONVERT) && coreRes.done;
    assign sampLast = {1'b0, sample_r.sampleWindowLen}
                    + SAMPLE_EXTRA - SAMPLE_ONE;
    assign lastSlot = (slotIdx_r == config_r.slotCount);

    always_comb
    begin
        state_nxt   = state_r;
        slotIdx_nxt = slotIdx_r;
        sampCnt_nxt = sampCnt_r;
        startPulse  = 1'b0;
        runClr      = 1'b0;
        eoseqSet    = 1'b0;
        unique case (state_r)
            ST_IDLE:
            begin
                if (run_r && ready_r)
                    state_nxt = ST_ARMED;
            end
            ST_ARMED:
            begin
                if (!run_r)
                begin
                    state_nxt   = ST_IDLE;
                    slotIdx_nxt = '0;
                end
                else if (trigHit)
                    state_nxt = ST_NEXT;
            end
            ST_NEXT:
            begin
                if (!run_r)
                begin
                    state_nxt   = ST_IDLE;
                    slotIdx_nxt = '0;
                end
                else if (!(config_r.waitMode && full_r))
                begin
                    state_nxt   = ST_SAMPLE;
                    sampCnt_nxt = '0;
                end
            end
            ST_SAMPLE:
            begin
                if (qTick)
                begin
                    if (sampCnt_r == sampLast)
                    begin
                        state_nxt  = ST_CONVERT;
                        startPulse = 1'b1;
                    end
                    else
                        sampCnt_nxt = sampCnt_r + SAMPLE_ONE;
                end
            end
            ST_CONVERT:
            begin
                if (coreRes.done)
                begin
                    if (lastSlot)
                    begin
                        slotIdx_nxt = '0;
                        eoseqSet    = 1'b1;
                        if (!hwMode && !config_r.repeatConversion)
                            runClr = 1'b1;
                    end
                    else
                        slotIdx_nxt = slotIdx_r + 3'h1;
                    if (!hwMode && config_r.splitSequenceEnable)
                        runClr = 1'b1;
                    if (runClr || !run_r)
                        state_nxt = ST_IDLE;
                    else if (config_r.splitSequenceEnable
                             || (lastSlot
                                 && !config_r.repeatConversion))
                        state_nxt = ST_ARMED;
                    else
                        state_nxt = ST_NEXT;
                end
            end
        endcase
        if (!enable_r)
        begin
            state_nxt   = ST_IDLE;
            slotIdx_nxt = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r   <= ST_IDLE;
            slotIdx_r <= '0;
            sampCnt_r <= '0;
        end
        else
        begin
            state_r   <= state_nxt;
            slotIdx_r <= slotIdx_nxt;
            sampCnt_r <= sampCnt_nxt;
        end
    end

    // Result formatting
    logic [2:0]       shiftAmt;
    logic [RAW_W-1:0] rawCut;
    logic [RES_W-1:0] rightWord;
    logic [RES_W-1:0] leftWord;
    logic [RES_W-1:0] resultWord;
    assign shiftAmt   = {config_r.bitDepthSelect, 1'b0};
    assign rawCut     = coreRes.data & (RAW_ONES << shiftAmt);
    assign rightWord  = RES_W'(rawCut >> shiftAmt);
    assign leftWord   = {rawCut, {PAD_W{1'b0}}};
    assign resultWord = config_r.alignRight ? rightWord : leftWord;

    // Holding register and overrun
    logic fullLive;
    logic ovrSet;
    logic loadHold;
    assign fullLive = full_r && !queueRd;
    assign ovrSet   = convDone && fullLive;
    assign loadHold = convDone
                   && (!fullLive || config_r.overflowPolicy);

    // Threshold guard
    logic guardChanOk;
    logic guardSet;
    assign guardChanOk = !guard_r.guardSingleChannel
                      || (convChannel_r == guard_r.guardChannel);
    assign guardSet = convDone && guard_r.guardEnable && guardChanOk
        && ((coreRes.data > limits_r.upperLimit)
            || (coreRes.data < limits_r.lowerLimit));

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hold_r <= '0;
            full_r <= 1'b0;
        end
        else
        begin
            if (loadHold)
                hold_r <= resultWord;
            full_r <= convDone || fullLive;
        end
    end

    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            eocFlag_r   <= 1'b0;
            eoseqFlag_r <= 1'b0;
            ovrFlag_r   <= 1'b0;
            guardFlag_r <= 1'b0;
        end
        else
        begin
            eocFlag_r <= convDone || (eocFlag_r && !queueRd
                && !(wrStatus && statusW.endOfConversionFlag));
            eoseqFlag_r <= eoseqSet || (eoseqFlag_r
                && !(wrStatus && statusW.endOfSequenceFlag));
            ovrFlag_r <= ovrSet || (ovrFlag_r
                && !(wrStatus && statusW.overflowFlag));
            guardFlag_r <= guardSet || (guardFlag_r
                && !(wrStatus && statusW.analogGuardFlag));
        end
    end

    // Read data
    asc_status_s  statusR;
    asc_control_s controlR;
    logic [DATA_W-1:0] rdMux;
    assign statusR = '{rsv: '0, ready: ready_r, queueFull: full_r,
                       analogGuardFlag: guardFlag_r,
                       overflowFlag: ovrFlag_r,
                       endOfSequenceFlag: eoseqFlag_r,
                       endOfConversionFlag: eocFlag_r};
    assign controlR = '{rsv: '0, convertRun: run_r, enable: enable_r};
    assign rdMux =
        (busReq.addr == OFS_STATUS)  ? DATA_W'(statusR)   :
        (busReq.addr == OFS_CONTROL) ? DATA_W'(controlR)  :
        (busReq.addr == OFS_SAMPLE)  ? DATA_W'(sample_r)  :
        (busReq.addr == OFS_CONFIG)  ? DATA_W'(config_r)  :
        (busReq.addr == OFS_CLKWARM) ? DATA_W'(clkWarm_r) :
        (busReq.addr == OFS_GUARD)   ? DATA_W'(guard_r)   :
        (busReq.addr == OFS_LIMITS)  ? DATA_W'(limits_r)  :
        (busReq.addr == OFS_SLOT_LO) ? slotLo_r           :
        (busReq.addr == OFS_SLOT_HI) ? slotHi_r           :
        (busReq.addr == OFS_QUEUE)   ? DATA_W'(hold_r)    :
        '0;

    always_ff @(posedge clk)
    begin
        if (rst || !busReq.rd)
            busRdata_r <= '0;
        else
            busRdata_r <= rdMux;
    end

    // Registered core-facing outputs
    logic idleNow;
    assign idleNow = (state_nxt == ST_IDLE) || (state_nxt == ST_ARMED);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            qclkEn_r       <= 1'b0;
            corePowerOn_r  <= 1'b0;
            sampleActive_r <= 1'b0;
            convertStart_r <= 1'b0;
            convChannel_r  <= '0;
            dmaReq_r       <= 1'b0;
        end
        else
        begin
            qclkEn_r       <= qTick;
            corePowerOn_r  <= enable_r
                && !(config_r.idlePowerDown && idleNow);
            sampleActive_r <= (state_nxt == ST_SAMPLE);
            convertStart_r <= startPulse;
            if (state_nxt == ST_SAMPLE && state_r != ST_SAMPLE)
                convChannel_r <= slotChan[slotIdx_r];
            dmaReq_r <= config_r.transferRequestEnable
                && (convDone || fullLive);
        end
    end

    assign busRdata     = busRdata_r;
    assign qclkEn       = qclkEn_r;
    assign corePowerOn  = corePowerOn_r;
    assign sampleActive = sampleActive_r;
    assign convertStart = convertStart_r;
    assign convChannel  = convChannel_r;
    assign bitDepth     = config_r.bitDepthSelect;
    assign dmaReq       = dmaReq_r;

endmodule : asc_sequencer_config

`default_nettype wire

// ---- verif/asc_core_model.sv ----
// Converter core model: answers each start with a result.
// Assumes the sequencer's core link on the same clock.
`timescale 1ns/1ps
`default_nettype none
module asc_core_model #(parameter int LAT = 3) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     convertStart,
    input  wire logic [asc_pkg::SLOT_W-1:0] convChannel,
    output asc_pkg::asc_core_res_s        coreRes
);
    import asc_pkg::*;
    int          cnt;
    logic [11:0] last;
    always_ff @(posedge clk)
    begin
        coreRes <= '{1'b0, ~last};
        if (rst)
        begin
            cnt  <= 0;
            last <= 12'h000;
        end
        else if (convertStart)
            cnt <= LAT;
        else if (cnt == 1)
        begin
            coreRes <= '{1'b1, {convChannel, 8'h5A}};
            last    <= {convChannel, 8'h5A};
            cnt     <= 0;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
    end
endmodule : asc_core_model
`default_nettype wire

// ---- verif/asc_sequencer_config_sva.sv ----
// Checker on the sequencer's ports.
// Bound onto asc_sequencer_config below.
`timescale 1ns/1ps
`default_nettype none
module asc_sequencer_config_sva (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire asc_pkg::asc_bus_req_s  busReq,
    input wire logic [31:0]            busRdata,
    input wire asc_pkg::asc_core_res_s coreRes,
    input wire logic                   qclkEn,
    input wire logic                   corePowerOn,
    input wire logic                   sampleActive,
    input wire logic                   convertStart,
    input wire logic [1:0]             bitDepth,
    input wire logic                   dmaReq
);
    import asc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0] div_r;
    logic [3:0] gap_r;
    logic       seen_r;
    wire        divWr = busReq.wr && busReq.addr == OFS_CLKWARM;
    wire        cfgWr = busReq.wr && busReq.addr == OFS_CONFIG;
    always_ff @(posedge clk)
    begin
        gap_r  <= qclkEn ? 4'h0 : gap_r + 4'h1;
        seen_r <= !rst && !divWr && (seen_r || qclkEn);
        div_r  <= rst ? 4'h0 : (divWr ? busReq.wdata[3:0] : div_r);
    end
    sequence s_startSoon;
        ##[0:1] convertStart;
    endsequence
    a_rdata_idle: assert property (!$past(busReq.rd) |-> busRdata == '0)
        else $error("read data not idle");
    a_queue_upper: assert property (busReq.rd && busReq.addr == OFS_QUEUE
        |=> busRdata[31:16] == '0) else $error("queue upper bits set");
    a_start_after: assert property ($fell(sampleActive) |-> s_startSoon)
        else $error("no start after sampling");
    a_start_single: assert property (convertStart |=> !convertStart)
        else $error("start pulse too long");
    a_depth_copy: assert property (cfgWr
        |-> ##2 bitDepth == $past(busReq.wdata[2:1], 2))
        else $error("bit depth not applied");
    a_tick_gap: assert property (qclkEn && seen_r |-> gap_r == div_r)
        else $error("converter clock spacing wrong");
    a_power_sample: assert property (sampleActive |-> corePowerOn)
        else $error("sampling with core off");
    a_dma_cause: assert property ($rose(dmaReq) |-> $past(coreRes.done))
        else $error("transfer request without result");
endmodule : asc_sequencer_config_sva
bind asc_sequencer_config asc_sequencer_config_sva chk_i (
    .clk(clk), .rst(rst), .busReq(busReq), .busRdata(busRdata),
    .coreRes(coreRes), .qclkEn(qclkEn), .corePowerOn(corePowerOn),
    .sampleActive(sampleActive), .convertStart(convertStart),
    .bitDepth(bitDepth), .dmaReq(dmaReq));
`default_nettype wire

// ---- verif/tb_asc_sequencer_config.sv ----
// Self-checking bench: register map and conversion runs.
// Core model answers each start with channel-tagged data.
`timescale 1ns/1ps
`default_nettype none
module tb_asc_sequencer_config;
    import asc_pkg::*;
    localparam logic [7:0] ADR [7] = '{OFS_SAMPLE, OFS_CONFIG,
        OFS_CLKWARM, OFS_GUARD, OFS_LIMITS, OFS_SLOT_LO, OFS_SLOT_HI};
    localparam logic [31:0] MSK [7] = '{SAMPLE_WMASK, CONFIG_WMASK,
        CLKWARM_WMASK, GUARD_WMASK, LIMITS_WMASK, SLOT_WMASK, SLOT_WMASK};
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    logic [7:0]    trigPins = 8'h00;
    asc_bus_req_s  busReq = '0;
    logic [31:0]   busRdata;
    asc_core_res_s coreRes;
    logic          convertStart;
    logic [3:0]    convChannel;
    int            failures = 0;
    int            comparisons = 0;
    initial forever #10 clk = ~clk;
    asc_sequencer_config uut (.clk(clk), .rst(rst), .busReq(busReq),
        .busRdata(busRdata), .trigPins(trigPins), .coreRes(coreRes),
        .qclkEn(), .corePowerOn(), .sampleActive(), .bitDepth(),
        .convertStart(convertStart), .convChannel(convChannel), .dmaReq());
    asc_core_model #(.LAT(3)) partner (.clk(clk), .rst(rst),
        .convertStart(convertStart), .convChannel(convChannel),
        .coreRes(coreRes));
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic print_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        busReq <= '0;
    endtask : wr
    task automatic rdc(input string n, input logic [7:0] a,
                       input logic [31:0] e);
        @(posedge clk);
        busReq <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        busReq <= '0;
        @(negedge clk);
        if (e !== 32'hFFFF_FFFF)
            chk(n, busRdata, e);
    endtask : rdc
    task automatic poll(input int b);
        for (int i = 0; i < 200; i++)
        begin
            rdc("status", OFS_STATUS, 32'hFFFF_FFFF);
            if (busRdata[b] === 1'b1)
                return;
        end
        chk("status poll", 32'h0, 32'h1);
        print_verdict();
    endtask : poll
    task automatic reg_map;
        logic [31:0] pat;
        rdc("sample reset", OFS_SAMPLE, 32'h0000_0002);
        rdc("unmapped", 8'h40, 32'h0000_0000);
        wr(OFS_QUEUE, 32'hFFFF_FFFF);
        rdc("queue", OFS_QUEUE, 32'h0000_0000);
        for (int i = 0; i < 14; i++)
        begin
            pat = i[0] ? 32'h0 : 32'hFFFF_FFFE;
            wr(ADR[i/2], pat);
            rdc("register", ADR[i/2], pat & MSK[i/2]);
        end
    endtask : reg_map
    task automatic conv_single;
        wr(OFS_CLKWARM, 32'h0000_0021);
        wr(OFS_SAMPLE, 32'h0000_0001);
        wr(OFS_SLOT_LO, 32'h0000_0003);
        wr(OFS_CONFIG, 32'h0000_0009);
        wr(OFS_CONTROL, 32'h0000_0001);
        poll(5);
        wr(OFS_CONTROL, 32'h0000_0003);
        poll(1);
        rdc("status", OFS_STATUS, 32'h0000_0033);
        rdc("result", OFS_QUEUE, 32'h0000_035A);
        rdc("status", OFS_STATUS, 32'h0000_0022);
        rdc("control", OFS_CONTROL, 32'h0000_0001);
        wr(OFS_STATUS, 32'h0000_000F);
    endtask : conv_single
    task automatic conv_overrun(input logic pol);
        wr(OFS_SLOT_LO, 32'h0000_0053);
        wr(OFS_GUARD, 32'h0000_0020);
        wr(OFS_LIMITS, 32'h0100_0000);
        wr(OFS_CONFIG, {14'h0, pol, 3'h1, 9'h0, pol, 4'h1});
        wr(OFS_CONTROL, 32'h0000_0003);
        trigPins <= {7'h0, pol};
        poll(1);
        rdc("status", OFS_STATUS, 32'h0000_003F);
        rdc("result", OFS_QUEUE, pol ? 32'h55A0 : 32'h35A0);
        wr(OFS_STATUS, 32'h0000_000F);
        rdc("status", OFS_STATUS, 32'h0000_0020);
    endtask : conv_overrun
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        reg_map();
        conv_single();
        conv_overrun(1'b0);
        conv_overrun(1'b1);
        print_verdict();
    end
endmodule : tb_asc_sequencer_config
`default_nettype wire
